// ==== include/mixer_pll_pkg.sv ====
// Summary of operation
// - phase shift adds to top 16 accumulator bits; sum addresses sine/cosine tables
// - with auto-sync enabled, phase shift write loads all three mixer words at once
// - frequency word writes only stage; active mixer unchanged until a sync
// - frequency word is 32-bit two's complement, low half then high half
// - pll reset bit clamps loop filter; clearing it restarts the pll
// - divider-alignment bit lets lvds sync input reset the n dividers
// - bit 10 selects pll clock, clear bypasses to the input clock
// - pump select 00 none, 01 single, 11 dual; 10 unused
// - prescaler codes 2..7 divide by code, 000 divides by 8
// - bits 2:0 read-only loop filter voltage indicator; writes ignored
package mixer_pll_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_RSVD_A = 10'h011;
    localparam logic [9:0] IDX_PHASE = 10'h012;
    localparam logic [9:0] IDX_RSVD_B = 10'h013;
    localparam logic [9:0] IDX_FREQ_LO = 10'h014;
    localparam logic [9:0] IDX_FREQ_HI = 10'h015;
    localparam logic [9:0] IDX_RSVD_C = 10'h016;
    localparam logic [9:0] IDX_RSVD_D = 10'h017;
    localparam logic [9:0] IDX_PLL = 10'h018;
    // mixer control, auto-sync enable in bit 0
    localparam logic [9:0] IDX_MIX_CTRL = 10'h020;
    localparam logic [11:0] OFS_RSVD_A = {IDX_RSVD_A, 2'h0};
    localparam logic [11:0] OFS_PHASE = {IDX_PHASE, 2'h0};
    localparam logic [11:0] OFS_RSVD_B = {IDX_RSVD_B, 2'h0};
    localparam logic [11:0] OFS_FREQ_LO = {IDX_FREQ_LO, 2'h0};
    localparam logic [11:0] OFS_FREQ_HI = {IDX_FREQ_HI, 2'h0};
    localparam logic [11:0] OFS_RSVD_C = {IDX_RSVD_C, 2'h0};
    localparam logic [11:0] OFS_RSVD_D = {IDX_RSVD_D, 2'h0};
    localparam logic [11:0] OFS_PLL = {IDX_PLL, 2'h0};
    localparam logic [11:0] OFS_MIX_CTRL = {IDX_MIX_CTRL, 2'h0};
    localparam int BIT_AUTOSYNC = 0;

    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam int BIT_PLL_RESET = 12;
    localparam int BIT_NDIV_SYNC = 11;
    localparam int BIT_PLL_ENA = 10;
    localparam int PUMP_HI = 7;
    localparam int PUMP_LO = 6;
    localparam int PRE_HI = 5;
    localparam int PRE_LO = 3;
    localparam int LFV_HI = 2;
    localparam int LFV_LO = 0;
    // writable bits of the pll word; 15:13 and 9:8 reserved, 2:0 read-only
    localparam logic [15:0] PLL_WMASK = 16'h1CF8;
    localparam logic [15:0] RST_PLL = 16'h2808;

    localparam logic [1:0] PUMP_NONE = 2'h0;
    localparam logic [1:0] PUMP_SINGLE = 2'h1;
    localparam logic [1:0] PUMP_DUAL = 2'h3;
    localparam logic [2:0] PRE_DIV8_CODE = 3'h0;
    localparam logic [3:0] PRE_DIV8 = 4'h8;

    localparam int LUT_ADDR_W = 8;
endpackage : mixer_pll_pkg

// ==== verilog/sincos_lut.sv ====
// quarter-free full table; registered outputs
module sincos_lut #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    // clock
    input wire logic pclk,
    // lookup
    input wire logic [AW-1:0] addr,
    output logic signed [DW-1:0] sin_q,
    output logic signed [DW-1:0] cos_q
);
    localparam int N = 1 << AW;
    logic signed [DW-1:0] sin_rom [N];
    logic signed [DW-1:0] cos_rom [N];

    generate
        for (genvar i = 0; i < N; i++) begin : g_rom
            localparam real PH = 6.283185307179586 * i / N;
            localparam real AMP = (2.0 ** (DW - 1)) - 1.0;
            assign sin_rom[i] = DW'($rtoi(AMP * $sin(PH)));
            assign cos_rom[i] = DW'($rtoi(AMP * $cos(PH)));
        end
    endgenerate

    always_ff @(posedge pclk) begin
        sin_q <= sin_rom[addr];
        cos_q <= cos_rom[addr];
    end
endmodule : sincos_lut

// ==== verilog/nco_mixer_and_pll_ctrl_regs.sv ====
// Implementation choice: register access over APB.
module nco_mixer_and_pll_ctrl_regs
    import mixer_pll_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pll side
    input wire logic lvds_sync,
    input wire logic [2:0] lf_volt_level,
    output logic lf_clamp,
    output logic pll_restart,
    output logic ndiv_sync,
    output logic use_pll_clk,
    output logic [1:0] pump_select,
    output logic [3:0] prescale_div,
    // mixer
    output logic [31:0] active_freq,
    output logic [15:0] active_phase,
    output logic mixer_sync,
    output logic signed [15:0] nco_sin,
    output logic signed [15:0] nco_cos
);
    logic [15:0] mixer_phase_shift;
    logic [15:0] osc_freq_low;
    logic [15:0] osc_freq_high;
    logic [15:0] pll_control_word;
    logic autosync_ena;
    logic [31:0] accum;
    logic [15:0] lut_sum;
    logic sync_m1, sync_m2, sync_prev;
    logic [2:0] lfv_m1, lfv_m2;
    logic wr_en, rd_en, pll_reset_prev;
    logic mapped;
    logic [3:0] next_div;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    always_comb begin
        unique case (paddr)
            OFS_RSVD_A, OFS_PHASE, OFS_RSVD_B, OFS_FREQ_LO, OFS_FREQ_HI,
            OFS_RSVD_C, OFS_RSVD_D, OFS_PLL, OFS_MIX_CTRL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // zero wait state answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mixer_phase_shift <= RST_REG16;
            osc_freq_low <= RST_REG16;
            osc_freq_high <= RST_REG16;
            autosync_ena <= 1'b0;
        end else if (wr_en) begin
            if (paddr == OFS_PHASE)
                mixer_phase_shift <= pwdata[15:0];
            if (paddr == OFS_FREQ_LO)
                osc_freq_low <= pwdata[15:0];
            if (paddr == OFS_FREQ_HI)
                osc_freq_high <= pwdata[15:0];
            if (paddr == OFS_MIX_CTRL)
                autosync_ena <= pwdata[BIT_AUTOSYNC];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_control_word <= RST_PLL;
        end else begin
            if (wr_en && paddr == OFS_PLL)
                pll_control_word <= (pwdata[15:0] & PLL_WMASK) | (RST_PLL & ~PLL_WMASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_freq <= 32'h0000_0000;
            active_phase <= RST_REG16;
            mixer_sync <= 1'b0;
        end else begin
            mixer_sync <= 1'b0;
            if (wr_en && paddr == OFS_PHASE && autosync_ena) begin
                active_freq <= {osc_freq_high, osc_freq_low};
                active_phase <= pwdata[15:0];
                mixer_sync <= 1'b1;
            end
        end
    end

    assign lut_sum = accum[31:16] + active_phase;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            accum <= 32'h0000_0000;
        else
            accum <= accum + active_freq;
    end

    sincos_lut #(.AW(LUT_ADDR_W), .DW(16)) u_lut (
        .pclk(pclk),
        .addr(lut_sum[15 -: LUT_ADDR_W]),
        .sin_q(nco_sin),
        .cos_q(nco_cos)
    );

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_m1 <= 1'b0;
            sync_m2 <= 1'b0;
            sync_prev <= 1'b0;
            lfv_m1 <= 3'h0;
            lfv_m2 <= 3'h0;
        end else begin
            sync_m1 <= lvds_sync;
            sync_m2 <= sync_m1;
            sync_prev <= sync_m2;
            lfv_m1 <= lf_volt_level;
            lfv_m2 <= lfv_m1;
        end
    end

    always_comb begin
        if (pll_control_word[PRE_HI:PRE_LO] == PRE_DIV8_CODE)
            next_div = PRE_DIV8;
        else
            next_div = {1'b0, pll_control_word[PRE_HI:PRE_LO]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_clamp <= 1'b0;
            pll_restart <= 1'b0;
            pll_reset_prev <= 1'b0;
            ndiv_sync <= 1'b0;
            use_pll_clk <= 1'b0;
            pump_select <= PUMP_NONE;
            prescale_div <= {1'b0, RST_PLL[PRE_HI:PRE_LO]};
        end else begin
            lf_clamp <= pll_control_word[BIT_PLL_RESET];
            pll_reset_prev <= pll_control_word[BIT_PLL_RESET];
            pll_restart <= pll_reset_prev && !pll_control_word[BIT_PLL_RESET];
            ndiv_sync <= pll_control_word[BIT_NDIV_SYNC] && sync_m2 && !sync_prev;
            use_pll_clk <= pll_control_word[BIT_PLL_ENA];
            pump_select <= pll_control_word[PUMP_HI:PUMP_LO];
            prescale_div <= next_div;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                OFS_PHASE: prdata <= {16'h0000, mixer_phase_shift};
                OFS_FREQ_LO: prdata <= {16'h0000, osc_freq_low};
                OFS_FREQ_HI: prdata <= {16'h0000, osc_freq_high};
                OFS_PLL: prdata <= {16'h0000, pll_control_word[15:3], lfv_m2};
                OFS_MIX_CTRL: prdata <= {31'h0000_0000, autosync_ena};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stage_no_effect: assert property (
        wr_en && paddr != OFS_PHASE |=> $stable(active_freq)) else $error("active freq moved without sync");
    a_autosync_load: assert property (
        wr_en && paddr == OFS_PHASE && autosync_ena
        |=> mixer_sync && active_phase == $past(pwdata[15:0])) else $error("auto-sync did not load");
    a_no_sync_when_off: assert property (
        !(wr_en && paddr == OFS_PHASE && autosync_ena) |=> !mixer_sync) else $error("spurious mixer sync");
    a_freq_pair: assert property (
        mixer_sync |-> active_freq == {osc_freq_high, osc_freq_low}) else $error("freq halves misordered");
    a_clamp_follows: assert property (
        pll_control_word[BIT_PLL_RESET] |=> lf_clamp) else $error("clamp not held");
    a_restart_pulse: assert property (
        $fell(pll_control_word[BIT_PLL_RESET]) |=> pll_restart ##1 !pll_restart) else $error("no restart");
    a_ndiv_gate: assert property (
        !pll_control_word[BIT_NDIV_SYNC] |=> !ndiv_sync) else $error("sync leaked");
    a_clk_select: assert property (
        ##1 use_pll_clk == $past(pll_control_word[BIT_PLL_ENA])) else $error("clock select wrong");
    a_prescale: assert property (
        pll_control_word[PRE_HI:PRE_LO] == PRE_DIV8_CODE |=> prescale_div == PRE_DIV8) else $error("div8 wrong");
    a_lfv_readonly: assert property (
        wr_en && paddr == OFS_PLL |=> pll_control_word[2:0] == RST_PLL[2:0]) else $error("lfv written");
    a_rsvd_hold: assert property (
        (pll_control_word & ~PLL_WMASK) == (RST_PLL & ~PLL_WMASK)) else $error("reserved changed");
    a_apb_ready: assert property (
        psel && !penable |=> pready) else $error("no ready");

    a_accum_step: assert property (
        1'b1
        |=> accum == $past(accum) + $past(active_freq))
        else $error("accumulator step wrong");

    a_lut_steady: assert property (
        active_freq == 32'h0000_0000 && !(wr_en && paddr == OFS_PHASE)
        |=> $stable(lut_sum))
        else $error("table address moved");

    a_lut_quarter: assert property (
        lut_sum == 16'h4000
        |=> nco_sin == 16'sh7FFF && nco_cos == 16'sh0000)
        else $error("quarter turn lookup wrong");

    a_lut_zero: assert property (
        lut_sum == 16'h0000
        |=> nco_sin == 16'sh0000 && nco_cos == 16'sh7FFF)
        else $error("zero phase lookup wrong");

    a_phase_hold: assert property (
        !(wr_en && paddr == OFS_PHASE && autosync_ena)
        |=> $stable(active_phase))
        else $error("active phase moved without sync");

    a_freq_hold: assert property (
        !(wr_en && paddr == OFS_PHASE && autosync_ena)
        |=> $stable(active_freq))
        else $error("active freq moved without sync");

    a_sync_single: assert property (
        mixer_sync
        |=> !mixer_sync)
        else $error("mixer sync too long");

    a_stage_low: assert property (
        wr_en && paddr == OFS_FREQ_LO
        |=> osc_freq_low == $past(pwdata[15:0]))
        else $error("low freq half not staged");

    a_stage_high: assert property (
        wr_en && paddr == OFS_FREQ_HI
        |=> osc_freq_high == $past(pwdata[15:0]))
        else $error("high freq half not staged");

    a_stage_phase: assert property (
        wr_en && paddr == OFS_PHASE
        |=> mixer_phase_shift == $past(pwdata[15:0]))
        else $error("phase shift not stored");

    a_ctrl_write: assert property (
        wr_en && paddr == OFS_MIX_CTRL
        |=> autosync_ena == $past(pwdata[BIT_AUTOSYNC]))
        else $error("auto-sync enable not stored");

    a_clamp_release: assert property (
        !pll_control_word[BIT_PLL_RESET]
        |=> !lf_clamp)
        else $error("clamp held after clear");

    a_restart_cause: assert property (
        pll_restart
        |-> !lf_clamp && $past(lf_clamp))
        else $error("restart without clamp release");

    a_ndiv_enabled: assert property (
        ndiv_sync
        |-> $past(pll_control_word[BIT_NDIV_SYNC]))
        else $error("divider sync while disabled");

    a_ndiv_single: assert property (
        ndiv_sync
        |=> !ndiv_sync)
        else $error("divider sync too long");

    a_pump_follow: assert property (
        1'b1
        |=> pump_select == $past(pll_control_word[PUMP_HI:PUMP_LO]))
        else $error("pump select wrong");

    a_prescale_code: assert property (
        pll_control_word[PRE_HI:PRE_LO] != PRE_DIV8_CODE
        |=> prescale_div == {1'b0, $past(pll_control_word[PRE_HI:PRE_LO])})
        else $error("prescaler division wrong");

    a_lfv_read: assert property (
        rd_en && paddr == OFS_PLL
        |=> prdata[LFV_HI:LFV_LO] == $past(lfv_m2))
        else $error("indicator not read back");

    a_pll_read: assert property (
        rd_en && paddr == OFS_PLL
        |=> prdata[15:3] == $past(pll_control_word[15:3]))
        else $error("pll word not read back");

    a_rsvd_read: assert property (
        rd_en && (paddr == OFS_RSVD_A || paddr == OFS_RSVD_B || paddr == OFS_RSVD_C || paddr == OFS_RSVD_D)
        |=> prdata == 32'h0000_0000)
        else $error("reserved register not zero");

    a_err_unmapped: assert property (
        psel && !penable && !mapped
        |=> pslverr)
        else $error("no error for unmapped address");

    a_err_mapped: assert property (
        psel && !penable && mapped
        |=> !pslverr)
        else $error("error for mapped address");

    a_freq_read: assert property (
        rd_en && paddr == OFS_FREQ_HI
        |=> prdata == {16'h0000, $past(osc_freq_high)})
        else $error("high freq half not read back");

    a_phase_read: assert property (
        rd_en && paddr == OFS_PHASE
        |=> prdata == {16'h0000, $past(mixer_phase_shift)})
        else $error("phase shift not read back");

    c_autosync: cover property (mixer_sync);
    c_restart: cover property (pll_restart);
    c_ndiv: cover property (ndiv_sync);
    c_err: cover property (pslverr);
    c_quarter: cover property (lut_sum == 16'h4000);
endmodule : nco_mixer_and_pll_ctrl_regs

// ==== sim/nco_mixer_and_pll_ctrl_regs_tb.sv ====
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("Error at %0t: got %h expected %h", $time, a, b); end end

module nco_mixer_and_pll_ctrl_regs_tb import mixer_pll_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic lvds_sync = 1'b0;
    logic [2:0] lf_volt_level = 3'h5;
    logic [31:0] prdata, active_freq, rd;
    logic pready, pslverr, lf_clamp, pll_restart, ndiv_sync, use_pll_clk, mixer_sync, err;
    logic [1:0] pump_select;
    logic [3:0] prescale_div;
    logic [15:0] active_phase;
    logic signed [15:0] nco_sin, nco_cos;
    logic [2:0] pulses;
    logic [11:0] rsv [4] = '{OFS_RSVD_A, OFS_RSVD_B, OFS_RSVD_C, OFS_RSVD_D};
    logic [1:0] pmp [3] = '{2'h0, 2'h1, 2'h3};
    int num_errors = 0;
    int checked = 0;
    int n;

    assign pulses = {ndiv_sync, pll_restart, mixer_sync};

    nco_mixer_and_pll_ctrl_regs nco_mixer_and_pll_ctrl_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lvds_sync(lvds_sync), .lf_volt_level(lf_volt_level), .lf_clamp(lf_clamp),
        .pll_restart(pll_restart), .ndiv_sync(ndiv_sync), .use_pll_clk(use_pll_clk),
        .pump_select(pump_select), .prescale_div(prescale_div), .active_freq(active_freq),
        .active_phase(active_phase), .mixer_sync(mixer_sync), .nco_sin(nco_sin), .nco_cos(nco_cos)
    );

    initial begin
        forever #20 pclk = ~pclk;
    end

    // one apb transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            num_errors++;
            finish_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000);
        `CHK(rd, exp)
    endtask : rchk

    // pulses seen on one strobe over a window
    task automatic count(input int k, input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge pclk);
            if (pulses[k] !== 1'b0) n = n + 1;
        end
    endtask : count

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (50000) @(posedge pclk);
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(use_pll_clk, 1'b0)
        rchk(OFS_PLL, 32'h0000_280D);
        `CHK(err, 1'b0)
        rchk(OFS_FREQ_HI, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, rsv[i], 16'hFFFF);
            rchk(rsv[i], 32'h0000_0000);
        end
        apb(1'b1, 12'h100, 16'h0001);
        `CHK(err, 1'b1)
        $display("test reset_and_reserved done");
        lvds_sync <= 1'b1;
        count(2, 8);
        `CHK(n, 1)
        lvds_sync <= 1'b0;
        apb(1'b1, OFS_PLL, 16'h0000);
        lvds_sync <= 1'b1;
        count(2, 8);
        `CHK(n, 0)
        lvds_sync <= 1'b0;
        $display("test divider_sync done");
        apb(1'b1, OFS_PLL, 16'hFFFF);
        repeat (2) @(posedge pclk);
        `CHK(lf_clamp, 1'b1)
        `CHK(use_pll_clk, 1'b1)
        rchk(OFS_PLL, 32'h0000_3CFD);
        apb(1'b1, OFS_PLL, 16'h0000);
        count(1, 4);
        `CHK(n, 1)
        `CHK(lf_clamp, 1'b0)
        `CHK(use_pll_clk, 1'b0)
        for (int p = 0; p < 8; p++) begin
            if (p == 1) continue;
            apb(1'b1, OFS_PLL, {8'h00, pmp[p % 3], p[2:0], 3'h0});
            repeat (2) @(posedge pclk);
            `CHK(pump_select, pmp[p % 3])
            `CHK(prescale_div, (p == 0) ? 4'h8 : 4'(p))
        end
        lf_volt_level <= 3'h2;
        repeat (3) @(posedge pclk);
        rchk(OFS_PLL, 32'h0000_207A);
        $display("test pll_fields done");
        apb(1'b1, OFS_FREQ_LO, 16'hBEEF);
        apb(1'b1, OFS_FREQ_HI, 16'h8001);
        apb(1'b1, OFS_PHASE, 16'h1234);
        count(0, 4);
        `CHK(n, 0)
        `CHK(active_freq, 32'h0000_0000)
        rchk(OFS_FREQ_HI, 32'h0000_8001);
        rchk(OFS_FREQ_LO, 32'h0000_BEEF);
        apb(1'b1, OFS_MIX_CTRL, 16'h0001);
        apb(1'b1, OFS_PHASE, 16'h4321);
        count(0, 4);
        `CHK(n, 1)
        `CHK(active_freq, 32'h8001_BEEF)
        `CHK(active_phase, 16'h4321)
        apb(1'b1, OFS_FREQ_LO, 16'h0001);
        repeat (3) @(posedge pclk);
        `CHK(active_freq, 32'h8001_BEEF)
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(active_freq, 32'h0000_0000)
        rchk(OFS_PHASE, 32'h0000_0000);
        apb(1'b1, OFS_MIX_CTRL, 16'h0001);
        apb(1'b1, OFS_PHASE, 16'h4000);
        repeat (3) @(posedge pclk);
        `CHK(nco_sin, 16'h7FFF)
        `CHK(nco_cos, 16'h0000)
        apb(1'b1, OFS_PHASE, 16'hC000);
        repeat (3) @(posedge pclk);
        `CHK(nco_sin, 16'h8001)
        `CHK(nco_cos, 16'h0000)
        $display("test mixer_sync done");
        finish_test();
    end
endmodule : nco_mixer_and_pll_ctrl_regs_tb
